// >>> verilog/sbr_defs.svh
// sbr_defs.svh: register indices, field positions, reset values
// assumes: included by sbr_pkg and by tb
`ifndef SBR_DEFS_SVH
`define SBR_DEFS_SVH

// register indices; byte address is index times four
`define SBR_IDX_STATUS   10'h050
`define SBR_IDX_DATA     10'h051
`define SBR_IDX_RATE     10'h052
`define SBR_IDX_FRAME    10'h053
`define SBR_IDX_ENABLE   10'h054
`define SBR_IDX_EXT_RX   10'h055
`define SBR_IDX_GAP      10'h056
`define SBR_IDX_EXT_TX   10'h057
`define SBR_ADDR_W       12

// status bits
`define SBR_SR_TXE       7
`define SBR_SR_TXC       6
`define SBR_SR_RXF       5
`define SBR_SR_IDLE      4
`define SBR_SR_OVR       3
`define SBR_SR_NOISE     2
`define SBR_SR_FRAME     1

// enable control bits
`define SBR_EN_TX        3
`define SBR_EN_RX        2

// frame format: bit 7 is the received ninth bit
`define SBR_FRM_RX9      7
`define SBR_FRM_WMASK    8'h58

// bit rate config fields
`define SBR_BRR_PRE_HI   7
`define SBR_BRR_PRE_LO   6
`define SBR_BRR_TXD_HI   5
`define SBR_BRR_TXD_LO   3
`define SBR_BRR_RXD_HI   2
`define SBR_BRR_RXD_LO   0

// reset values
`define SBR_STATUS_RST   8'hC0
`define SBR_ENABLE_RST   8'h00
`define SBR_EXT_RST      8'h00
`define SBR_PRE_RST      2'h0
`define SBR_BYTE_RST     8'h00

// prescale factors and fixed stage
`define SBR_PR_F0        4'h1
`define SBR_PR_F1        4'h3
`define SBR_PR_F2        4'h4
`define SBR_PR_F3        4'hD
`define SBR_SUB_LAST     4'hF
`define SBR_SUB_DIV      16'h0010

`endif

// >>> verilog/sbr_pkg.sv
// sbr_pkg: shared types and the prescale lookup
// assumes: sbr_defs.svh on the include path
`include "sbr_defs.svh"

package sbr_pkg;

    typedef logic [7:0] sbr_byte_type;

    // status-read arming for the clear sequences
    typedef enum logic [0:0] {
        SBR_SEQ_IDLE  = 1'b0,
        SBR_SEQ_ARMED = 1'b1
    } sbr_seq_type;

    function automatic logic [3:0] sbr_prescale_factor(input logic [1:0] sel);
        logic [3:0] f;
        f = `SBR_PR_F0;
        case (sel)
            2'h0: f = `SBR_PR_F0;
            2'h1: f = `SBR_PR_F1;
            2'h2: f = `SBR_PR_F2;
            default: f = `SBR_PR_F3;
        endcase
        return f;
    endfunction

endpackage

// >>> verilog/sbr_rate_gen.sv
// sbr_rate_gen: one bit-rate tick generator (prescale, /16, divisor)
// assumes: configuration is quasi-static, from the same pclk domain
`timescale 1ns/10ps
`default_nettype none

module sbr_rate_gen
    import sbr_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [1:0] prescale_sel,
    input  wire logic [2:0] div_sel,
    input  wire logic [7:0] ext_div,
    output logic            rate_tick
);

    logic [3:0] pre_q, pre_d, pr_lim;
    logic [3:0] sub_q, sub_d;
    logic [7:0] div_q, div_d, div_lim;
    logic       tick_q, tick_d;
    logic       pre_wrap, sub_wrap, div_wrap;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        pr_lim = sbr_prescale_factor(prescale_sel);
        div_lim = (ext_div != 8'h00) ? ext_div : (8'h01 << div_sel);
        pre_wrap = (pre_q >= pr_lim - 4'h1);
        sub_wrap = (sub_q == `SBR_SUB_LAST);
        // >= so a lowered limit never lets a counter run away
        div_wrap = (div_q >= div_lim - 8'h01);
        pre_d = pre_wrap ? 4'h0 : pre_q + 4'h1;
        sub_d = pre_wrap ? sub_q + 4'h1 : sub_q;
        div_d = div_q;
        if (pre_wrap && sub_wrap) begin
            div_d = div_wrap ? 8'h00 : div_q + 8'h01;
        end
        tick_d = pre_wrap && sub_wrap && div_wrap;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q  <= 4'h0;
            sub_q  <= 4'h0;
            div_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            pre_q  <= pre_d;
            sub_q  <= sub_d;
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign rate_tick = tick_q;

    ////////////////////////////////////////////////////////////////////////
    // period checker; skips periods in which the settings moved
    logic [15:0] gap_q, period;
    logic [12:0] cfg_q;
    logic        seen_q, chg_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q  <= 16'h0000;
            cfg_q  <= 13'h0000;
            seen_q <= 1'b0;
            chg_q  <= 1'b1;
        end else begin
            gap_q  <= tick_q ? 16'h0000 : gap_q + 16'h0001;
            cfg_q  <= {prescale_sel, div_sel, ext_div};
            seen_q <= seen_q | tick_q;
            chg_q  <= ({prescale_sel, div_sel, ext_div} != cfg_q) | (chg_q & !tick_q);
        end
    end

    assign period = 16'(pr_lim) * 16'(div_lim) * `SBR_SUB_DIV;

    a_rate_period: assert property (@(posedge pclk) disable iff (!presetn)
        (tick_q && seen_q && !chg_q && ({prescale_sel, div_sel, ext_div} == cfg_q))
        |-> (gap_q == period - 16'h0001))
        else $error("rate tick period wrong");

endmodule

`default_nettype wire

// >>> verilog/sbr_top.sv
// sbr_top: async serial unit data path, flags and bit-rate generators
// assumes: APB3 master on pclk; shift registers and framing logic
// sit outside on the same clock and talk through pulses and levels
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none

module sbr_top
    import sbr_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic [`SBR_ADDR_W-1:0] paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  tx_shift_ready,
    output logic                       tx_shift_load,
    output logic      [7:0]            tx_shift_data,
    input  wire logic                  tx_frame_done,
    input  wire logic                  rx_shift_done,
    input  wire logic [7:0]            rx_shift_data,
    input  wire logic                  rx_ninth_bit,
    input  wire logic                  rx_idle_evt,
    input  wire logic                  rx_noise_evt,
    input  wire logic                  rx_frame_err_evt,
    output logic                       tx_rate_tick,
    output logic                       rx_rate_tick,
    output logic      [7:0]            frame_format,
    output logic      [7:0]            enable_ctrl
);

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic [9:0] idx;
    logic       acc, wr_acc, rd_acc, setup;
    logic       hit, sel_sr, sel_dr, sel_brr, sel_frm, sel_en, sel_erx, sel_etx;
    logic       sel_gap;

    always_comb begin
        idx     = paddr[`SBR_ADDR_W-1:2];
        sel_sr  = (idx == `SBR_IDX_STATUS);
        sel_dr  = (idx == `SBR_IDX_DATA);
        sel_brr = (idx == `SBR_IDX_RATE);
        sel_frm = (idx == `SBR_IDX_FRAME);
        sel_en  = (idx == `SBR_IDX_ENABLE);
        sel_erx = (idx == `SBR_IDX_EXT_RX);
        sel_gap = (idx == `SBR_IDX_GAP);
        sel_etx = (idx == `SBR_IDX_EXT_TX);
        hit     = sel_sr | sel_dr | sel_brr | sel_frm | sel_en | sel_erx
                | sel_gap | sel_etx;
        setup   = psel && !penable;
        acc     = psel && penable;
        wr_acc  = acc && pwrite;
        rd_acc  = acc && !pwrite;
    end

    // zero wait states: read data is prepared in the setup cycle
    assign pready  = 1'b1;
    assign pslverr = acc && !hit;

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    sbr_byte_type brr_q, brr_d;
    sbr_byte_type frm_q, frm_d;
    sbr_byte_type en_q, en_d;
    sbr_byte_type erx_q, erx_d;
    sbr_byte_type etx_q, etx_d;
    sbr_byte_type tx_hold_q, tx_hold_d;
    sbr_byte_type stat_q, stat_d;

    always_comb begin
        brr_d     = brr_q;
        frm_d     = frm_q;
        en_d      = en_q;
        erx_d     = erx_q;
        etx_d     = etx_q;
        tx_hold_d = tx_hold_q;
        // data writes go to tx holding
        if (wr_acc && sel_dr) begin
            tx_hold_d = pwdata[7:0];
        end
        if (wr_acc && sel_brr) begin
            brr_d = pwdata[7:0];
        end
        if (wr_acc && sel_frm) begin
            frm_d = (frm_q & ~`SBR_FRM_WMASK) | (pwdata[7:0] & `SBR_FRM_WMASK);
        end
        if (wr_acc && sel_en) begin
            en_d = pwdata[7:0];
        end
        if (wr_acc && sel_erx) begin
            erx_d = pwdata[7:0];
        end
        if (wr_acc && sel_etx) begin
            etx_d = pwdata[7:0];
        end
        // ninth bit arrives with the character it belongs to
        if (rx_shift_done && en_q[`SBR_EN_RX] && !stat_q[`SBR_SR_RXF]) begin
            frm_d[`SBR_FRM_RX9] = rx_ninth_bit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // prescale bits cleared, rest zero too
            brr_q     <= {`SBR_PRE_RST, 6'h00};
            frm_q     <= `SBR_BYTE_RST;
            en_q      <= `SBR_ENABLE_RST;
            erx_q     <= `SBR_EXT_RST;
            etx_q     <= `SBR_EXT_RST;
            tx_hold_q <= `SBR_BYTE_RST;
        end else begin
            brr_q     <= brr_d;
            frm_q     <= frm_d;
            en_q      <= en_d;
            erx_q     <= erx_d;
            etx_q     <= etx_d;
            tx_hold_q <= tx_hold_d;
        end
    end

    assign frame_format = frm_q;
    assign enable_ctrl  = en_q;

    ////////////////////////////////////////////////////////////////////////
    // status flags, rx holding, tx hand-off
    sbr_byte_type rx_hold_q, rx_hold_d;
    sbr_byte_type txd_q, txd_d;
    sbr_seq_type  seq_q, seq_d;
    logic         load_q, load_d;
    logic         idle_lock_q, idle_lock_d;
    logic         rx_take, rx_ovr, tx_clr, rx_clr;

    always_comb begin
        stat_d      = stat_q;
        rx_hold_d   = rx_hold_q;
        txd_d       = txd_q;
        seq_d       = seq_q;
        idle_lock_d = idle_lock_q;
        // sequence: status read, then data write
        tx_clr = wr_acc && sel_dr && (seq_q == SBR_SEQ_ARMED);
        // sequence: status read, then data read
        rx_clr = rd_acc && sel_dr && (seq_q == SBR_SEQ_ARMED);
        if (acc && sel_dr) begin
            seq_d = SBR_SEQ_IDLE;
        end
        if (rd_acc && sel_sr) begin
            seq_d = SBR_SEQ_ARMED;
        end
        if (tx_clr) begin
            stat_d[`SBR_SR_TXE] = 1'b0;
            stat_d[`SBR_SR_TXC] = 1'b0;
        end
        if (rx_clr) begin
            stat_d[`SBR_SR_RXF:`SBR_SR_FRAME] = 5'h00;
        end
        // no hand-off while tx empty set
        load_d = !stat_q[`SBR_SR_TXE] && en_q[`SBR_EN_TX] && tx_shift_ready;
        if (load_d) begin
            txd_d = tx_hold_q;
            stat_d[`SBR_SR_TXE] = 1'b1;
        end
        // set wins over a clear in the same cycle
        if (tx_frame_done) begin
            stat_d[`SBR_SR_TXC] = 1'b1;
        end
        rx_take = rx_shift_done && en_q[`SBR_EN_RX];
        rx_ovr  = rx_take && stat_q[`SBR_SR_RXF];
        if (rx_take && !rx_ovr) begin
            rx_hold_d = rx_shift_data;
            stat_d[`SBR_SR_RXF] = 1'b1;
            idle_lock_d = 1'b0;
            if (rx_noise_evt) begin
                stat_d[`SBR_SR_NOISE] = 1'b1;
            end
            if (rx_frame_err_evt) begin
                stat_d[`SBR_SR_FRAME] = 1'b1;
            end
        end
        // held character survives; only overrun is flagged
        if (rx_ovr) begin
            stat_d[`SBR_SR_OVR] = 1'b1;
        end
        // idle re-arms only after a new character
        if (rx_idle_evt && en_q[`SBR_EN_RX] && !idle_lock_q) begin
            stat_d[`SBR_SR_IDLE] = 1'b1;
            idle_lock_d = 1'b1;
        end
        if (!en_q[`SBR_EN_RX]) begin
            stat_d[`SBR_SR_RXF:`SBR_SR_FRAME] = 5'h00;
        end
        stat_d[0] = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q      <= `SBR_STATUS_RST;
            rx_hold_q   <= `SBR_BYTE_RST;
            txd_q       <= `SBR_BYTE_RST;
            seq_q       <= SBR_SEQ_IDLE;
            load_q      <= 1'b0;
            idle_lock_q <= 1'b0;
        end else begin
            stat_q      <= stat_d;
            rx_hold_q   <= rx_hold_d;
            txd_q       <= txd_d;
            seq_q       <= seq_d;
            load_q      <= load_d;
            idle_lock_q <= idle_lock_d;
        end
    end

    assign tx_shift_load = load_q;
    assign tx_shift_data = txd_q;

    ////////////////////////////////////////////////////////////////////////
    // read data, captured in the setup cycle
    sbr_byte_type rdat_q, rdat_d;

    always_comb begin
        rdat_d = rdat_q;
        if (setup) begin
            rdat_d = 8'h00;
            case (1'b1)
                sel_sr:  rdat_d = stat_q;
                sel_dr:  rdat_d = rx_hold_q;
                sel_brr: rdat_d = brr_q;
                sel_frm: rdat_d = frm_q;
                sel_en:  rdat_d = en_q;
                sel_erx: rdat_d = erx_q;
                sel_etx: rdat_d = etx_q;
                default: rdat_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdat_q <= 8'h00;
        end else begin
            rdat_q <= rdat_d;
        end
    end

    assign prdata = {24'h000000, rdat_q};

    ////////////////////////////////////////////////////////////////////////
    // rate generators
    // tx rate from prescale, divisor
    sbr_rate_gen u_tx_rate (
        .pclk         (pclk),
        .presetn      (presetn),
        .prescale_sel (brr_q[`SBR_BRR_PRE_HI:`SBR_BRR_PRE_LO]),
        .div_sel      (brr_q[`SBR_BRR_TXD_HI:`SBR_BRR_TXD_LO]),
        .ext_div      (etx_q),
        .rate_tick    (tx_rate_tick)
    );

    sbr_rate_gen u_rx_rate (
        .pclk         (pclk),
        .presetn      (presetn),
        .prescale_sel (brr_q[`SBR_BRR_PRE_HI:`SBR_BRR_PRE_LO]),
        .div_sel      (brr_q[`SBR_BRR_RXD_HI:`SBR_BRR_RXD_LO]),
        .ext_div      (erx_q),
        .rate_tick    (rx_rate_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic first_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    sequence s_sr_read;
        rd_acc && sel_sr;
    endsequence

    sequence s_dr_write;
        wr_acc && sel_dr;
    endsequence

    sequence s_dr_read;
        rd_acc && sel_dr;
    endsequence

    a_reset_values: assert property (first_q |->
        stat_q == `SBR_STATUS_RST && erx_q == 8'h00 && etx_q == 8'h00
        && brr_q[7:6] == 2'h0)
        else $error("reset values wrong");

    a_tx_clear_seq: assert property (s_sr_read ##3 s_dr_write |=>
        !stat_q[`SBR_SR_TXE])
        else $error("tx empty not cleared by sequence");

    a_tx_hold_block: assert property ($rose(load_q) |->
        !$past(stat_q[`SBR_SR_TXE]) ##1 stat_q[`SBR_SR_TXE])
        else $error("hand-off while tx empty set");

    a_tx_transfer: assert property (load_q |->
        tx_shift_data == $past(tx_hold_q))
        else $error("shifter got wrong character");

    a_rx_clear_seq: assert property (s_sr_read ##3 (s_dr_read and !rx_shift_done)
        |=> !stat_q[`SBR_SR_RXF])
        else $error("rx full not cleared by sequence");

    a_rx_off_clear: assert property (!en_q[`SBR_EN_RX] |=>
        stat_q[`SBR_SR_RXF:`SBR_SR_FRAME] == 5'h00)
        else $error("rx flags kept while receiver off");

    a_rx_transfer: assert property (
        (rx_shift_done && en_q[`SBR_EN_RX] && !stat_q[`SBR_SR_RXF])
        |=> rx_hold_q == $past(rx_shift_data) && stat_q[`SBR_SR_RXF])
        else $error("rx holding not loaded");

    a_dr_write_hold: assert property (s_dr_write |=>
        tx_hold_q == $past(pwdata[7:0]))
        else $error("data write lost");

    a_dr_read_data: assert property ((setup && sel_dr && !rx_shift_done) ##1 acc
        |-> prdata[7:0] == rx_hold_q)
        else $error("data read wrong");

    a_gap_reads_zero: assert property (rd_acc && sel_gap |->
        prdata == 32'h00000000 && !pslverr)
        else $error("hole not zero");

endmodule

`default_nettype wire

// >>> bench/sbr_link_model.sv
// sbr_link_model: far-side shift registers facing the data path
// assumes: same pclk; the bench commands the receive side
`timescale 1ns/10ps
`default_nettype none

module sbr_link_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       slow,
    input  wire logic       rx_go,
    input  wire logic [7:0] rx_val,
    input  wire logic       rx_bad,
    input  wire logic       tx_shift_load,
    input  wire logic [7:0] tx_shift_data,
    output logic            tx_shift_ready,
    output logic            tx_frame_done,
    output logic            rx_shift_done,
    output logic [7:0]      rx_shift_data,
    output logic            rx_ninth_bit,
    output logic            rx_noise_evt,
    output logic            rx_frame_err_evt,
    output logic [7:0]      tx_got,
    output int              tx_loads
);
    int         cnt;
    logic [7:0] last_q;
    logic       bad_q;

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_shift_ready <= 1'b1;
            tx_frame_done  <= 1'b0;
            tx_got         <= 8'h00;
            tx_loads       <= 0;
            cnt            <= 0;
        end else begin
            tx_frame_done <= 1'b0;
            if (tx_shift_load) begin
                tx_got         <= tx_shift_data;
                tx_loads       <= tx_loads + 1;
                tx_shift_ready <= 1'b0;
                cnt            <= slow ? 40 : 3;
            end else if (cnt == 1) begin
                tx_frame_done  <= 1'b1;
                tx_shift_ready <= 1'b1;
                cnt            <= 0;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_shift_done <= 1'b0;
            bad_q         <= 1'b0;
            last_q        <= 8'h00;
        end else begin
            rx_shift_done <= rx_go;
            bad_q         <= rx_go & rx_bad;
            if (rx_go) begin
                last_q <= rx_val;
            end
        end
    end

    // character valid with strobe
    // outside the strobe the bus shows junk, so a late sample is caught
    assign rx_shift_data    = rx_shift_done ? last_q : ~last_q;
    assign rx_ninth_bit     = rx_shift_done ? ^last_q : ~^last_q;
    assign rx_noise_evt     = bad_q;
    assign rx_frame_err_evt = bad_q;
endmodule

`default_nettype wire

// >>> bench/tb.sv
// tb: register map, clear sequences, data hand-off and rate ticks
// assumes: sbr_top on one pclk, far side from sbr_link_model
`timescale 1ns/10ps
`default_nettype none
`include "sbr_defs.svh"

module tb;
    import sbr_pkg::*;
    localparam logic [9:0] I_ST = `SBR_IDX_STATUS;
    localparam logic [9:0] I_DT = `SBR_IDX_DATA;
    localparam logic [9:0] I_BR = `SBR_IDX_RATE;
    localparam logic [9:0] I_FR = `SBR_IDX_FRAME;
    localparam logic [9:0] I_EN = `SBR_IDX_ENABLE;
    localparam logic [9:0] I_XR = `SBR_IDX_EXT_RX;
    localparam logic [9:0] I_GP = `SBR_IDX_GAP;
    localparam logic [9:0] I_XT = `SBR_IDX_EXT_TX;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
    logic tx_shift_ready, tx_shift_load, tx_frame_done, rx_shift_done;
    logic rx_ninth_bit, rx_noise_evt, rx_frame_err_evt, tx_rate_tick, rx_rate_tick;
    logic slow, rx_go, rx_bad;
    logic [`SBR_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [7:0] tx_shift_data, rx_shift_data, frame_format, enable_ctrl, tx_got, rx_val, d;
    logic [23:0] rt [6] = '{24'h000000, 24'h4A0000, 24'h9D0000, 24'hC00000,
                            24'h470501, 24'h0001FF};
    int tx_loads, n_errors, checks_done, seed, k;

    sbr_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .tx_shift_ready, .tx_shift_load, .tx_shift_data,
        .tx_frame_done, .rx_shift_done, .rx_shift_data, .rx_ninth_bit,
        .rx_idle_evt(1'b0), .rx_noise_evt, .rx_frame_err_evt, .tx_rate_tick,
        .rx_rate_tick, .frame_format, .enable_ctrl);
    sbr_link_model link (.pclk, .presetn, .slow, .rx_go, .rx_val, .rx_bad,
        .tx_shift_load, .tx_shift_data, .tx_shift_ready, .tx_frame_done,
        .rx_shift_done, .rx_shift_data, .rx_ninth_bit, .rx_noise_evt,
        .rx_frame_err_evt, .tx_got, .tx_loads);

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // entered just after a rising edge; one idle cycle after each transfer
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        v = prdata;
        err_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(v, exp);
    endtask

    task automatic send(input logic [7:0] b, input logic bad);
        rx_val <= b;
        rx_bad <= bad;
        rx_go  <= 1'b1;
        @(posedge pclk);
        rx_go <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    function automatic int period(input logic [7:0] br, input logic [7:0] x, input logic tx);
        int pr;
        int dv;
        pr = (br[7:6] == 2'h0) ? 1 : (br[7:6] == 2'h1) ? 3 : (br[7:6] == 2'h2) ? 4 : 13;
        dv = 1 << (tx ? br[5:3] : br[2:0]);
        if (x != 8'h00) begin
            dv = x;
        end
        return pr * 16 * dv;
    endfunction

    task automatic gap(input logic tx, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((tx ? tx_rate_tick : rx_rate_tick) !== 1'b1 && n < 60000);
    endtask

    // first period after a change may be irregular, so two are skipped
    task automatic rate_case(input logic [7:0] br, input logic [7:0] xt, input logic [7:0] xr);
        int n;
        apb(1'b1, I_BR, br);
        apb(1'b1, I_XT, xt);
        apb(1'b1, I_XR, xr);
        rdc(I_BR, {24'h0, br});
        rdc(I_XT, {24'h0, xt});
        repeat (3) gap(1'b1, n);
        chk(n, period(br, xt, 1'b1));
        repeat (3) gap(1'b0, n);
        chk(n, period(br, xr, 1'b0));
        $display("test rate %h %h %h done", br, xt, xr);
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        // tests need about 55k cycles; the time limit falls at 80k cycles
        #640000;
        n_errors++;
        finish_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, slow, rx_go, rx_bad} = '0;
        paddr = '0;
        pwdata = '0;
        rx_val = 8'h00;
        n_errors = 0;
        checks_done = 0;
        seed = 32'h452d0b5c;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(I_ST, 32'hC0);
        rdc(I_XR, 32'h0);
        rdc(I_XT, 32'h0);
        apb(1'b0, I_BR, 8'h00);
        chk(v[7:6], 2'h0);
        apb(1'b1, I_GP, 8'hFF);
        rdc(I_GP, 32'h0);
        apb(1'b1, I_FR, 8'hFF);
        rdc(I_FR, 32'h58);
        chk(frame_format, 8'h58);
        apb(1'b1, I_ST, 8'h00);
        rdc(I_ST, 32'hC0);
        rdc(10'h0A0, 32'h0);
        chk(err_q, 1'b1);
        $display("test map done");
        // a data access drops the arming left by the status reads above
        apb(1'b0, I_DT, 8'h00);
        apb(1'b1, I_EN, 8'h0C);
        chk(enable_ctrl, 8'h0C);
        apb(1'b1, I_DT, 8'h5A);
        repeat (8) @(posedge pclk);
        chk(tx_loads, 0);
        for (int i = 0; i < 4; i++) begin
            slow <= i[0];
            d = $random(seed);
            rdc(I_ST, 32'hC0);
            apb(1'b1, I_DT, d);
            for (k = 0; k < 200 && !(tx_loads == i + 1 && tx_shift_ready); k++) @(posedge pclk);
            chk(tx_loads, i + 1);
            chk(tx_got, d);
        end
        $display("test transmit done");
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            send(d, 1'b0);
            rdc(I_ST, 32'hE0);
            rdc(I_DT, {24'h0, d});
            chk(frame_format[7], ^d);
            rdc(I_ST, 32'hC0);
        end
        send(8'h3C, 1'b1);
        send(8'hA5, 1'b0);
        rdc(I_ST, 32'hEE);
        apb(1'b1, I_EN, 8'h08);
        rdc(I_ST, 32'hC0);
        send(8'h11, 1'b0);
        rdc(I_ST, 32'hC0);
        apb(1'b1, I_EN, 8'h0C);
        $display("test receive done");
        foreach (rt[j]) rate_case(rt[j][23:16], rt[j][15:8], rt[j][7:0]);
        for (int i = 0; i < 3; i++) begin
            d = $random(seed);
            rate_case(d & 8'hDB, 8'h00, 8'h00);
        end
        finish_test();
    end
endmodule

`default_nettype wire
